// [inc/pow_map.svh]
// constants of the one-wire readout link: timing, packet layout, mode codes
`ifndef POW_MAP_SVH
`define POW_MAP_SVH
// ==================================================
// clock
`define POW_CLK_MHZ 40
// ==================================================
// timing, figures in their own unit
`define POW_SAMPLE_PERIOD_MS 16
`define POW_FORCED_START_HIGH_US 110
`define POW_ALARM_CLEAR_LOW_US 35
`define POW_ABORT_LOW_US 145
`define POW_BIT_HOLD_US 10
// derived cycle counts (all whole multiples of the period)
`define POW_SAMPLE_PERIOD_CYC (`POW_SAMPLE_PERIOD_MS * 1000 * `POW_CLK_MHZ)
`define POW_FORCED_START_HIGH_CYC (`POW_FORCED_START_HIGH_US * `POW_CLK_MHZ)
`define POW_ALARM_CLEAR_LOW_CYC (`POW_ALARM_CLEAR_LOW_US * `POW_CLK_MHZ)
`define POW_ABORT_LOW_CYC (`POW_ABORT_LOW_US * `POW_CLK_MHZ)
`define POW_BIT_HOLD_CYC (`POW_BIT_HOLD_US * `POW_CLK_MHZ)
// ==================================================
// packet layout
`define POW_PKT_BITS 40
`define POW_PKT_MSB 39
`define POW_ADC_BITS 14
`define POW_CFG_BITS 25
// ==================================================
// operation mode codes
`define POW_MODE_FORCED 2'h0
`define POW_MODE_IRQ 2'h1
`define POW_MODE_ALARM 2'h2
`define POW_MODE_RSVD 2'h3
`endif

// [inc/pow_pkg.sv]
// types of the one-wire readout link
`default_nettype none
`include "pow_map.svh"
package pow_pkg;
  typedef enum logic [1:0] {
    POW_MODE_FORCED_E = `POW_MODE_FORCED,
    POW_MODE_IRQ_E = `POW_MODE_IRQ,
    POW_MODE_ALARM_E = `POW_MODE_ALARM,
    POW_MODE_RSVD_E = `POW_MODE_RSVD
  } pow_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ANNOUNCE,
    ST_ALARM,
    ST_WAIT_RISE,
    ST_BIT_DRIVE,
    ST_WAIT_LOW
  } pow_state_t;
endpackage
`default_nettype wire

// [rtl/pow_sample_timer.sv]
// free-running sample period timer, one-cycle tick per period
`timescale 1ns/100ps
`default_nettype none
`include "pow_map.svh"
module pow_sample_timer #(
  parameter int unsigned PERIOD_CYC = `POW_SAMPLE_PERIOD_CYC
) (
  input wire logic clk, // system clock
  input wire logic rst_n, // synchronised reset, active low
  output logic tick // one-cycle pulse each period
);
  localparam int W = $clog2(PERIOD_CYC + 1);
  logic [W-1:0] count;
  // ==================================================
  // period counter, wraps at the end of each period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count == W'(PERIOD_CYC - 1)) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + W'(1);
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// [rtl/pow_link.sv]
// one-wire readout link, device end
// Behaviour
// - interrupt mode: drive line high each period
// - after start, wait host rising edge first
// - per bit: pull low for zero
// - line low 145 us aborts transfer
// - packet: flag, 14-bit value, configuration
// - alarm: hold high until 35 us low
// - two-bit mode selects readout or alarm
`timescale 1ns/100ps
`default_nettype none
`include "pow_map.svh"
module pow_link
  import pow_pkg::*;
#(
  parameter int unsigned SAMPLE_CYC = `POW_SAMPLE_PERIOD_CYC,
  parameter int unsigned FORCED_HIGH_CYC = `POW_FORCED_START_HIGH_CYC,
  parameter int unsigned ABORT_LOW_CYC = `POW_ABORT_LOW_CYC,
  parameter int unsigned CLEAR_LOW_CYC = `POW_ALARM_CLEAR_LOW_CYC,
  parameter int unsigned BIT_HOLD_CYC = `POW_BIT_HOLD_CYC
) (
  input wire logic clk, // 40 MHz clock
  input wire logic resetn, // async reset, active low
  input wire logic line_in, // resolved level of the wire
  output logic line_out, // level driven on the wire
  output logic line_oe, // high while driving the wire
  input wire logic [1:0] mode, // operation mode setting
  input wire logic input_reset_flag, // 0 after input reset
  input wire logic [`POW_ADC_BITS-1:0] adc_value, // converter value
  input wire logic [`POW_CFG_BITS-1:0] config_word, // configuration
  input wire logic motion_event, // motion detected pulse
  output logic busy, // readout in progress
  output logic alarm_active, // alarm held on the wire
  output logic packet_done, // pulse: last bit presented
  output logic readout_abort // pulse: host cancelled
);
  localparam int CW = 16;
  localparam int IW = 6;
  // ==================================================
  // reset release through two flip-flops
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end
  // ==================================================
  // sample period
  logic sample_tick;
  pow_sample_timer #(
    .PERIOD_CYC(SAMPLE_CYC)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .tick(sample_tick)
  );
  // ==================================================
  // line history and level timers
  pow_state_t state;
  logic line_prev;
  logic [CW-1:0] low_cnt;
  logic [CW-1:0] high_cnt;
  logic [CW-1:0] hold_cnt;
  logic [IW-1:0] bit_idx;
  logic [`POW_PKT_BITS-1:0] shifter;
  logic self_low;
  logic rise;
  logic fall;
  logic start_forced;
  assign self_low = line_oe && !line_out;
  assign rise = line_in && !line_prev;
  assign fall = !line_in && line_prev;
  // forced start: long enough high phase ended by a fall
  assign start_forced = fall && (high_cnt >= CW'(FORCED_HIGH_CYC));
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_prev <= 1'b1; // idle level of the pulled-up wire, no false rise
    end else begin
      line_prev <= line_in;
    end
  end
  // low time made by the host, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_cnt <= '0;
    end else if (line_in || self_low) begin
      low_cnt <= '0;
    end else if (low_cnt != '1) begin
      low_cnt <= low_cnt + CW'(1);
    end
  end
  // high time of the wire, saturating
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_cnt <= '0;
    end else if (!line_in) begin
      high_cnt <= '0;
    end else if (high_cnt != '1) begin
      high_cnt <= high_cnt + CW'(1);
    end
  end
  // ==================================================
  // main sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (mode == POW_MODE_FORCED_E && start_forced) begin
            state <= ST_WAIT_RISE;
          end else if (mode == POW_MODE_IRQ_E && sample_tick) begin
            state <= ST_ANNOUNCE;
          end else if (mode == POW_MODE_ALARM_E && motion_event) begin
            state <= ST_ALARM;
          end
        end
        ST_ANNOUNCE: begin
          if (!line_in) begin
            state <= ST_WAIT_RISE;
          end
        end
        ST_ALARM: begin
          if (low_cnt >= CW'(CLEAR_LOW_CYC)) begin
            state <= ST_IDLE;
          end
        end
        ST_WAIT_RISE: begin
          if (low_cnt >= CW'(ABORT_LOW_CYC)) begin
            state <= ST_IDLE;
          end else if (rise) begin
            state <= ST_BIT_DRIVE;
          end
        end
        ST_BIT_DRIVE: begin
          if (hold_cnt == CW'(BIT_HOLD_CYC - 1)) begin
            state <= (bit_idx == '0) ? ST_IDLE : ST_WAIT_LOW;
          end
        end
        ST_WAIT_LOW: begin
          if (!line_in) begin
            state <= ST_WAIT_RISE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  // bit presentation time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_cnt <= '0;
    end else if (state == ST_BIT_DRIVE) begin
      hold_cnt <= hold_cnt + CW'(1);
    end else begin
      hold_cnt <= '0;
    end
  end
  // packet capture at start, shift msb first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shifter <= '0;
      bit_idx <= '0;
    end else if ((state == ST_IDLE && mode == POW_MODE_FORCED_E && start_forced)
                 || (state == ST_IDLE && mode == POW_MODE_IRQ_E && sample_tick)) begin
      shifter <= {input_reset_flag, adc_value, config_word};
      bit_idx <= IW'(`POW_PKT_MSB);
    end else if (state == ST_BIT_DRIVE && hold_cnt == CW'(BIT_HOLD_CYC - 1)) begin
      shifter <= {shifter[`POW_PKT_BITS-2:0], 1'b0};
      bit_idx <= bit_idx - IW'(1);
    end
  end
  // ==================================================
  // wire drive: high to announce or alarm, low for a zero bit
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      line_oe <= 1'b0;
      line_out <= 1'b0;
    end else begin
      case (state)
        ST_ANNOUNCE: begin
          line_oe <= line_in;
          line_out <= 1'b1;
        end
        ST_ALARM: begin
          line_oe <= 1'b1;
          line_out <= 1'b1;
        end
        ST_BIT_DRIVE: begin
          line_oe <= !shifter[`POW_PKT_MSB] && hold_cnt != CW'(BIT_HOLD_CYC - 1);
          line_out <= 1'b0;
        end
        default: begin
          line_oe <= 1'b0;
          line_out <= 1'b0;
        end
      endcase
    end
  end
  // status outputs and event pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      alarm_active <= 1'b0;
      packet_done <= 1'b0;
      readout_abort <= 1'b0;
    end else begin
      busy <= state == ST_WAIT_RISE || state == ST_BIT_DRIVE || state == ST_WAIT_LOW;
      alarm_active <= state == ST_ALARM;
      packet_done <= state == ST_BIT_DRIVE && bit_idx == '0 && hold_cnt == CW'(BIT_HOLD_CYC - 1);
      readout_abort <= state == ST_WAIT_RISE && low_cnt >= CW'(ABORT_LOW_CYC);
    end
  end
  // ==================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence idle_tick_s;
    state == ST_IDLE && mode == POW_MODE_IRQ_E && sample_tick;
  endsequence
  sequence drive_high_s;
    line_oe && line_out;
  endsequence
  irq_announce_a: assert property (idle_tick_s |-> ##1 state == ST_ANNOUNCE ##1 (drive_high_s or !line_in))
    else $error("announce did not drive the line high");
  wait_rise_a: assert property (state == ST_WAIT_RISE && !rise && low_cnt < CW'(ABORT_LOW_CYC)
                                |=> state == ST_WAIT_RISE && !line_oe)
    else $error("bit presented before a host rising edge");
  zero_bit_a: assert property (state == ST_WAIT_RISE && rise && low_cnt < CW'(ABORT_LOW_CYC)
                               |=> ##1 (line_oe == !$past(shifter[`POW_PKT_MSB])))
    else $error("bit level not driven as shifted value");
  one_bit_a: assert property (state == ST_BIT_DRIVE && shifter[`POW_PKT_MSB] |=> !line_oe)
    else $error("one bit drove the line");
  abort_low_a: assert property (state == ST_WAIT_RISE && low_cnt >= CW'(ABORT_LOW_CYC)
                                |=> state == ST_IDLE && readout_abort)
    else $error("long low did not end the transfer");
  packet_load_a: assert property (idle_tick_s |=> shifter == $past({input_reset_flag, adc_value, config_word})
                                  && bit_idx == IW'(`POW_PKT_MSB))
    else $error("packet not captured in layout");
  forced_start_a: assert property (state == ST_IDLE && mode == POW_MODE_FORCED_E && fall
                                   && high_cnt < CW'(FORCED_HIGH_CYC) |=> state == ST_IDLE)
    else $error("short high phase started a readout");
  alarm_hold_a: assert property (state == ST_ALARM && low_cnt < CW'(CLEAR_LOW_CYC)
                                 |=> state == ST_ALARM ##1 drive_high_s)
    else $error("alarm released early");
  mode_rsvd_a: assert property (state == ST_IDLE && mode == POW_MODE_RSVD_E |=> state == ST_IDLE)
    else $error("reserved mode left idle");
  msb_first_a: assert property (state == ST_BIT_DRIVE && hold_cnt == CW'(BIT_HOLD_CYC - 1)
                                |=> shifter == {$past(shifter[`POW_PKT_BITS-2:0]), 1'b0})
    else $error("packet not shifted msb first");
endmodule
`default_nettype wire

// [dv/pow_host_model.sv]
// host side of the one-wire line, driven on the falling edge
`timescale 1ns/100ps
`default_nettype none
module pow_host_model #(
  parameter int HOLD = 8
) (
  input wire logic clk, // system clock
  input wire logic line_in, // resolved wire level
  output logic host_oe, // high while host drives
  output logic host_out // level host drives
);
  // ==========
  // released at start, listening as input
  initial begin
    host_oe = 1'b0;
    host_out = 1'b1;
  end
  // drive a level for n cycles
  task automatic drive(input logic lvl, input int n);
    host_oe = 1'b1;
    host_out = lvl;
    repeat (n) @(negedge clk);
  endtask
  // let go of the wire for at least one cycle, pull-up takes it high
  task automatic release_line();
    host_oe = 1'b0;
    host_out = 1'b1;
    @(negedge clk);
  endtask
  // forced start: long high, then low
  task automatic start(input int hi);
    drive(1'b1, hi);
    drive(1'b0, 4);
  endtask
  // one slot: raise, release, sample, then low past the hold
  task automatic read_bit(output logic b);
    drive(1'b1, 1);
    release_line();
    repeat (3) @(negedge clk);
    b = line_in;
    drive(1'b0, HOLD + 2);
  endtask
  // whole packet, closing low then release
  task automatic read_packet(output logic [39:0] p);
    for (int i = 39; i >= 0; i--) begin
      read_bit(p[i]);
    end
    drive(1'b0, 20);
    release_line();
  endtask
endmodule
`default_nettype wire

// [dv/testbench.sv]
// testbench of the one-wire readout link with a host model
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pow_pkg::*;
  localparam int HOLD = 8;
  localparam int SAMPLE = 2000;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] mode = 2'h3;
  logic flag = 1'b1;
  logic [13:0] adc = 14'h0000;
  logic [24:0] cfg = 25'h0000000;
  logic motion_event = 1'b0;
  logic line_out, line_oe, busy, alarm_active, packet_done, readout_abort, host_oe, host_out, line_w;
  logic done_seen = 1'b0;
  logic abort_seen = 1'b0;
  logic [39:0] got;
  int failures = 0;
  int samples_checked = 0;
  int cyc = 0;
  // ==========
  // wire with pull-up: any low driver wins
  assign line_w = ~((host_oe & ~host_out) | (line_oe & ~line_out));
  pow_link #(.SAMPLE_CYC(SAMPLE), .FORCED_HIGH_CYC(40), .ABORT_LOW_CYC(200), .CLEAR_LOW_CYC(20),
    .BIT_HOLD_CYC(HOLD)) u_pow_link (.clk(clk), .resetn(resetn), .line_in(line_w), .line_out(line_out),
    .line_oe(line_oe), .mode(mode), .input_reset_flag(flag), .adc_value(adc), .config_word(cfg),
    .motion_event(motion_event), .busy(busy), .alarm_active(alarm_active), .packet_done(packet_done),
    .readout_abort(readout_abort));
  pow_host_model #(.HOLD(HOLD)) u_pow_host_model (.clk(clk), .line_in(line_w), .host_oe(host_oe),
    .host_out(host_out));
  // 40 MHz clock
  always #12.5 clk = ~clk;
  // cycle count and sticky capture of pulses
  always @(posedge clk) begin
    cyc++;
    if (packet_done === 1'b1) done_seen <= 1'b1;
    if (readout_abort === 1'b1) abort_seen <= 1'b1;
  end
  // ==========
  task automatic tally_and_finish();
    if (failures == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bounded wait for the device to drive the wire
  task automatic wait_oe(input int n, output int at);
    for (int i = 0; i < n && line_oe !== 1'b1; i++) @(negedge clk);
    at = cyc;
    if (line_oe !== 1'b1) begin
      failures++;
      tally_and_finish();
    end
  endtask
  // ==========
  // forced readout of a full packet
  task automatic forced_read();
    mode = 2'h0;
    adc = 14'h2A5C;
    cfg = 25'h15A3C69;
    done_seen = 1'b0;
    u_pow_host_model.start(50);
    check(busy, 1'b1);
    u_pow_host_model.read_packet(got);
    check(got, {1'b1, 14'h2A5C, 25'h15A3C69});
    check({done_seen, busy}, 2'b10);
    mode = 2'h3;
  endtask
  // short high in readout mode, falls in alarm and reserved modes
  task automatic start_refused();
    logic [1:0] modes [3] = '{2'h0, 2'h2, 2'h3};
    int highs [3] = '{20, 50, 50};
    for (int k = 0; k < 3; k++) begin
      mode = 2'h3;
      u_pow_host_model.drive(1'b0, 4);
      mode = modes[k];
      u_pow_host_model.start(highs[k]);
      u_pow_host_model.release_line();
      check(busy, 1'b0);
    end
    mode = 2'h3;
  endtask
  // cancel after five bits by a long low
  task automatic cancel_mid();
    logic b;
    mode = 2'h0;
    abort_seen = 1'b0;
    u_pow_host_model.start(50);
    repeat (5) u_pow_host_model.read_bit(b);
    u_pow_host_model.drive(1'b0, 210);
    u_pow_host_model.release_line();
    check({abort_seen, busy}, 2'b10);
    mode = 2'h3;
  endtask
  // alarm held until a long enough low
  task automatic alarm_clear();
    mode = 2'h2;
    motion_event = 1'b1;
    @(negedge clk);
    motion_event = 1'b0;
    repeat (3) @(negedge clk);
    check({line_oe, line_out, alarm_active}, 3'b111);
    u_pow_host_model.drive(1'b0, 10);
    u_pow_host_model.release_line();
    @(negedge clk);
    check({line_oe, alarm_active}, 2'b11);
    u_pow_host_model.drive(1'b0, 25);
    u_pow_host_model.release_line();
    repeat (3) @(negedge clk);
    check({line_oe, alarm_active}, 2'b00);
    mode = 2'h3;
  endtask
  // announce each period, readout between announces
  task automatic irq_read();
    int t0;
    int t1;
    int t2;
    mode = 2'h1;
    flag = 1'b0;
    adc = 14'h1357;
    cfg = 25'h0F0F0F0;
    wait_oe(SAMPLE + 10, t0);
    check(line_out, 1'b1);
    u_pow_host_model.drive(1'b0, 3);
    check({line_oe, busy}, 2'b01);
    u_pow_host_model.drive(1'b0, 6);
    t2 = cyc;
    u_pow_host_model.read_packet(got);
    check(cyc - t2 < 32000, 1'b1);
    check(got, {1'b0, 14'h1357, 25'h0F0F0F0});
    wait_oe(SAMPLE, t1);
    check(t1 - t0, SAMPLE);
    u_pow_host_model.drive(1'b0, 210);
    mode = 2'h3;
    u_pow_host_model.release_line();
  endtask
  // ==========
  // reset, then scenarios in turn
  initial begin
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    forced_read();
    start_refused();
    cancel_mid();
    alarm_clear();
    irq_read();
    tally_and_finish();
  end
  // cut a hang short
  initial begin
    #2500000;
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
